// file: verilog/pus_pkg.sv
// Package of constants for the power-up supervisor
// Overview of operation
// - Valid supply and enable: sequence, then alert low
// - Enable low keeps the block in Off
// - Input below lockout threshold turns converter off
// - Lockout threshold is a 4-bit code field
// - Threshold resets to lowest code, writable anytime
// - Undervoltage must persist 150 us before shutdown
// - External bias bit resets 0, 1 disables regulator
// - USB rail undervoltage flag below 2.7 V
// - USB rail overvoltage flag above 4.0 V
// - Logic runs only while bias above lockout; here the USB rail flags still follow their comparators in lockout
package pus_pkg;
	localparam int CLK_MHZ = 200;
	localparam int BLANK_US = 150;
	localparam int BLANK_CYCLES = BLANK_US * CLK_MHZ;
	localparam int THRESH_W = 4;
	localparam logic [3:0] THRESH_RESET = 4'h0;
	localparam logic [3:0] THRESH_MAX = 4'hA;
	localparam int SEQ_STEP_CYCLES = 16;
	localparam logic EXT_BIAS_RESET = 1'b0;
	typedef enum logic [1:0] {PUS_OFF, PUS_START, PUS_RUN} pus_state_t;
endpackage : pus_pkg

// file: verilog/pus_blank_timer.sv
// Persistence timer: output rises after input has stayed high long enough
`timescale 1ns/1ps
`default_nettype none
module pus_blank_timer #(
	parameter int COUNT = 30000
) (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic condIn,
	output logic persisted
);
	localparam int CW = $clog2(COUNT + 1);
	logic [CW-1:0] count_reg;

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			count_reg <= '0;
		else if (!condIn)
			count_reg <= '0;
		else if (count_reg != CW'(COUNT))
			count_reg <= count_reg + 1'b1;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			persisted <= 1'b0;
		else
			persisted <= condIn && (count_reg >= CW'(COUNT - 1));
	end
endmodule : pus_blank_timer
`default_nettype wire

// file: verilog/power_up_supervisor.sv
// Power-up sequencing and supply supervision logic
`timescale 1ns/1ps
`default_nettype none
module power_up_supervisor
	import pus_pkg::*;
#(
	parameter int BLANK_COUNT = BLANK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic high_voltage_enable_in,
	input wire logic biasAboveLockout,
	input wire logic [THRESH_W-1:0] input_undervolt_threshold,
	input wire logic thresholdWrite,
	input wire logic externalBiasWrite,
	input wire logic externalBiasData,
	input wire logic [10:0] inputBelowCode,
	input wire logic usbRailBelowUv,
	input wire logic usbRailAboveOv,
	output logic alertOutN,
	output logic alertOutOe,
	output logic buckBoostEnable,
	output logic internalBiasEnable,
	output logic external_bias_select,
	output logic [THRESH_W-1:0] thresholdCode,
	output logic usb_rail_undervolt_flag,
	output logic usb_rail_overvolt_flag,
	output logic startupDone
);
	logic rstSync1_reg;
	logic rstSync2_reg;
	logic rstN;
	pus_state_t state_reg;
	logic [4:0] step_reg;
	logic [THRESH_W-1:0] thresh_reg;
	logic [THRESH_W-1:0] effCode;
	logic belowNow;
	logic uvPersisted;

	// ****************************************
	// Reset release; rst_n deasserts through two synchronizing flops
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end
		else
		begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	assign rstN = rstSync2_reg;

	// ****************************************
	// Threshold and bias configuration
	// ****************************************
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			thresh_reg <= THRESH_RESET;
		else if (!biasAboveLockout)
			thresh_reg <= THRESH_RESET;
		else if (thresholdWrite)
			thresh_reg <= input_undervolt_threshold;
	end

	// Code above the top setting clamps, so the bank index stays in range
	always_comb
	begin
		if (thresh_reg > THRESH_MAX)
			effCode = THRESH_MAX;
		else
			effCode = thresh_reg;
	end
	// Comparator bank gives one "below" bit per setting
	assign belowNow = inputBelowCode[effCode];

	// ****************************************
	// Bias supply selection
	// ****************************************
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			external_bias_select <= EXT_BIAS_RESET;
		else if (!biasAboveLockout || state_reg == PUS_OFF)
			external_bias_select <= EXT_BIAS_RESET;
		else if (externalBiasWrite && state_reg == PUS_RUN)
			external_bias_select <= externalBiasData;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			internalBiasEnable <= 1'b1;
		else
			internalBiasEnable <= !external_bias_select;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			thresholdCode <= THRESH_RESET;
		else
			thresholdCode <= effCode;
	end

	// ****************************************
	// Input undervoltage blanking
	// ****************************************
	pus_blank_timer #(
		.COUNT(BLANK_COUNT)
	) i_pus_blank_timer (
		.mclk(mclk),
		.rstN(rstN),
		.condIn(belowNow),
		.persisted(uvPersisted)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			state_reg <= PUS_OFF;
		else
		begin
			case (state_reg)
				PUS_OFF:
				begin
					if (high_voltage_enable_in && biasAboveLockout && !belowNow)
						state_reg <= PUS_START;
				end
				PUS_START:
				begin
					if (!high_voltage_enable_in || !biasAboveLockout)
						state_reg <= PUS_OFF;
					else if (step_reg == 5'(SEQ_STEP_CYCLES - 1))
						state_reg <= PUS_RUN;
				end
				PUS_RUN:
				begin
					if (!high_voltage_enable_in || !biasAboveLockout)
						state_reg <= PUS_OFF;
				end
				default:
					state_reg <= PUS_OFF;
			endcase
		end
	end

	// ****************************************
	// Start-up step counter
	// ****************************************
	// Counts only in START; any other state rearms it for the next attempt
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			step_reg <= '0;
		else if (state_reg == PUS_START)
			step_reg <= step_reg + 1'b1;
		else
			step_reg <= '0;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Open drain: only ever pulls low; the level is held high while released
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			alertOutN <= 1'b1;
		else
			alertOutN <= (state_reg != PUS_RUN);
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			alertOutOe <= 1'b0;
		else
			alertOutOe <= (state_reg == PUS_RUN);
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			startupDone <= 1'b0;
		else
			startupDone <= (state_reg == PUS_RUN);
	end

	// Converter stops on a blanked undervoltage; short dips ride through
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			buckBoostEnable <= 1'b0;
		else
			buckBoostEnable <= (state_reg == PUS_RUN) && !uvPersisted;
	end

	// ****************************************
	// USB rail status flags
	// ****************************************
	// Comparators are taken as synchronous; a slow rail may chatter here
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			usb_rail_undervolt_flag <= 1'b0;
		else
			usb_rail_undervolt_flag <= usbRailBelowUv;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			usb_rail_overvolt_flag <= 1'b0;
		else
			usb_rail_overvolt_flag <= usbRailAboveOv;
	end
endmodule : power_up_supervisor
`default_nettype wire

// file: tb/pus_supervisor_asserts.sv
// Port checker of the power-up supervisor
`timescale 1ns/1ps
`default_nettype none
module pus_supervisor_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic high_voltage_enable_in,
	input wire logic biasAboveLockout,
	input wire logic thresholdWrite,
	input wire logic [3:0] input_undervolt_threshold,
	input wire logic [3:0] thresholdCode,
	input wire logic usbRailBelowUv,
	input wire logic usbRailAboveOv,
	input wire logic alertOutN,
	input wire logic alertOutOe,
	input wire logic buckBoostEnable,
	input wire logic internalBiasEnable,
	input wire logic external_bias_select,
	input wire logic startupDone,
	input wire logic usb_rail_undervolt_flag,
	input wire logic usb_rail_overvolt_flag
);
	// Depth 3 skips the reset release flops, so the uv, ov, bias and threshold checks never compare reset values
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_uv_flag: assert property ($past(rst_n, 3) |-> usb_rail_undervolt_flag == $past(usbRailBelowUv))
		else $error("uv");
	chk_ov_flag: assert property ($past(rst_n, 3) |-> usb_rail_overvolt_flag == $past(usbRailAboveOv))
		else $error("ov");
	chk_bias_inv: assert property ($past(rst_n, 3) |-> internalBiasEnable != $past(external_bias_select))
		else $error("bias");
	chk_off_low: assert property ((!high_voltage_enable_in)[*3] |-> !startupDone)
		else $error("off");
	chk_lock_clear: assert property ((!biasAboveLockout)[*3] |-> !startupDone
		&& !external_bias_select && thresholdCode == 4'h0) else $error("lockout");
	chk_alert_run: assert property (alertOutOe == startupDone && !(alertOutOe && alertOutN))
		else $error("alert");
	chk_thr_write: assert property (thresholdWrite && biasAboveLockout && $past(rst_n, 3) |-> ##2
		thresholdCode == ($past(input_undervolt_threshold, 2) > 4'hA ? 4'hA
		: $past(input_undervolt_threshold, 2))) else $error("threshold");
	chk_bb_run: assert property (buckBoostEnable |-> startupDone)
		else $error("converter");
endmodule : pus_supervisor_asserts
bind power_up_supervisor pus_supervisor_asserts i_pus_supervisor_asserts (
	.mclk(mclk),
	.rst_n(rst_n),
	.high_voltage_enable_in(high_voltage_enable_in),
	.biasAboveLockout(biasAboveLockout),
	.thresholdWrite(thresholdWrite),
	.input_undervolt_threshold(input_undervolt_threshold),
	.thresholdCode(thresholdCode),
	.usbRailBelowUv(usbRailBelowUv),
	.usbRailAboveOv(usbRailAboveOv),
	.alertOutN(alertOutN),
	.alertOutOe(alertOutOe),
	.buckBoostEnable(buckBoostEnable),
	.internalBiasEnable(internalBiasEnable),
	.external_bias_select(external_bias_select),
	.startupDone(startupDone),
	.usb_rail_undervolt_flag(usb_rail_undervolt_flag),
	.usb_rail_overvolt_flag(usb_rail_overvolt_flag)
);
`default_nettype wire

// file: tb/pus_host_model.sv
// Host model issuing configuration writes
`timescale 1ns/1ps
`default_nettype none
module pus_host_model (
	input wire logic mclk,
	input wire logic alertOutOe,
	output logic [3:0] input_undervolt_threshold = 4'h0,
	output logic thresholdWrite = 1'b0,
	output logic externalBiasWrite = 1'b0,
	output logic externalBiasData = 1'b0
);
	// Released data shows the inverse, so a stale value is never read as valid
	task automatic put(input logic ext, input logic [3:0] v);
		wait (alertOutOe === 1'b1);
		@(negedge mclk);
		{thresholdWrite, externalBiasWrite, input_undervolt_threshold, externalBiasData} = {!ext, ext, v, v[0]};
		@(negedge mclk);
		{thresholdWrite, externalBiasWrite, input_undervolt_threshold, externalBiasData} = {2'h0, ~v, ~v[0]};
	endtask : put
endmodule : pus_host_model
`default_nettype wire

// file: tb/tb_power_up_supervisor.sv
// Self-checking bench of the power-up supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: %h %h", $time, a, e); end end
module tb_power_up_supervisor;
	logic mclk = 1'b0, rst_n = 1'b0, en = 1'b0, bias = 1'b1, usbRailBelowUv = 1'b0;
	logic usbRailAboveOv = 1'b0, thresholdWrite, externalBiasWrite, externalBiasData, done;
	logic alertOutN, alertOutOe, buckBoostEnable, internalBiasEnable, external_bias_select;
	logic usb_rail_undervolt_flag, usb_rail_overvolt_flag;
	logic [3:0] input_undervolt_threshold, code, v;
	logic [10:0] below = 11'h000;
	int failures = 0, cmp_count = 0, cyc = 0, lvl;
	always #2.5 mclk = ~mclk;
	power_up_supervisor #(
		.BLANK_COUNT(20)
	) i_power_up_supervisor (
		.mclk(mclk),
		.rst_n(rst_n),
		.high_voltage_enable_in(en),
		.biasAboveLockout(bias),
		.input_undervolt_threshold(input_undervolt_threshold),
		.thresholdWrite(thresholdWrite),
		.externalBiasWrite(externalBiasWrite),
		.externalBiasData(externalBiasData),
		.inputBelowCode(below),
		.usbRailBelowUv(usbRailBelowUv),
		.usbRailAboveOv(usbRailAboveOv),
		.alertOutN(alertOutN),
		.alertOutOe(alertOutOe),
		.buckBoostEnable(buckBoostEnable),
		.internalBiasEnable(internalBiasEnable),
		.external_bias_select(external_bias_select),
		.thresholdCode(code),
		.usb_rail_undervolt_flag(usb_rail_undervolt_flag),
		.usb_rail_overvolt_flag(usb_rail_overvolt_flag),
		.startupDone(done)
	);
	pus_host_model i_pus_host_model (
		.mclk(mclk),
		.alertOutOe(alertOutOe),
		.input_undervolt_threshold(input_undervolt_threshold),
		.thresholdWrite(thresholdWrite),
		.externalBiasWrite(externalBiasWrite),
		.externalBiasData(externalBiasData)
	);
	// Threshold code in use: writes above the top setting clamp to it
	function automatic logic [3:0] exp_code(input logic [3:0] c);
		return (c > pus_pkg::THRESH_MAX) ? pus_pkg::THRESH_MAX : c;
	endfunction : exp_code
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic boot();
		for (int i = 0; i < 40 && done !== 1'b1; i++)
			@(negedge mclk);
		`CHK({done, alertOutOe, alertOutN, buckBoostEnable}, 4'hD)
	endtask : boot
	always @(posedge mclk)
		if (++cyc == 9000)
		begin
			failures++;
			finish_test();
		end
	initial
	begin
		void'($urandom(32'h6F6AE675));
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		repeat (30) @(negedge mclk);
		`CHK({done, alertOutOe, alertOutN, buckBoostEnable, internalBiasEnable, external_bias_select, code}, 10'h0A0)
		en = 1'b1;
		boot();
		for (int k = 0; k < 12; k++)
		begin
			v = k == 0 ? 4'hF : k == 1 ? 4'h0 : 4'($urandom_range(15));
			lvl = $urandom_range(11);
			i_pus_host_model.put(1'b0, v);
			@(negedge mclk);
			`CHK(code, exp_code(v))
			{usbRailBelowUv, usbRailAboveOv} = 2'($urandom_range(3));
			below = 11'h7FF << lvl;
			repeat (10) @(negedge mclk);
			`CHK({usb_rail_undervolt_flag, usb_rail_overvolt_flag}, {usbRailBelowUv, usbRailAboveOv})
			below = 11'h000;
			@(negedge mclk);
			below = 11'h7FF << lvl;
			repeat (18) @(negedge mclk);
			`CHK(buckBoostEnable, 1'b1)
			repeat (6) @(negedge mclk);
			`CHK(buckBoostEnable, lvl > exp_code(v))
			below = 11'h000;
			en = buckBoostEnable;
			repeat (3) @(negedge mclk);
			`CHK({done, alertOutOe}, {en, en})
			en = 1'b1;
			boot();
		end
		i_pus_host_model.put(1'b1, 4'h1);
		@(negedge mclk);
		`CHK({external_bias_select, internalBiasEnable}, 2'h2)
		bias = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK({done, external_bias_select, code}, 6'h00)
		bias = 1'b1;
		boot();
		finish_test();
	end
endmodule : tb_power_up_supervisor
`default_nettype wire
